// file: testbench/pcg_core_model.sv
// Purpose: core side issuing unit accesses
// Assumes: one clock, strobes one cycle
// Notes: idle strobes are zero
`timescale 1ns/100ps
`default_nettype none
module pcg_core_model (
   input wire logic pclk, // Clock
   output logic [4:0] unit_access // Strobes
);
   initial unit_access = 5'h00;
   // One cycle access attempt per set bit
   task automatic access(input logic [4:0] m);
      @(posedge pclk);
      unit_access <= m;
      @(posedge pclk);
      unit_access <= 5'h00;
   endtask
endmodule
`default_nettype wire

// file: testbench/pcg_top_asserts.sv
// Purpose: port checks of the gating block
// Assumes: ports of pcg_top only
// Notes: bound after the module
`timescale 1ns/100ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_top_asserts #(
   parameter [1:0] MAX_RATE = 2'h2
) (
   input wire logic pclk, // Clk
   input wire logic presetn, // Rst
   input wire logic psel, // Sel
   input wire logic penable, // En
   input wire logic pwrite, // Dir
   input wire logic [11:0] paddr, // Addr
   input wire logic [31:0] pwdata, // Wdata
   input wire logic [31:0] prdata, // Rdata
   input wire logic pready, // Rdy
   input wire logic pslverr, // Err
   input wire logic [1:0] power_mode, // Mode
   input wire logic [4:0] unit_access, // Strobes
   input wire logic can_unit_zero_gate, // Can
   input wire logic pwm_gate, // Pwm
   input wire logic adc_gate, // Adc
   input wire logic hibernation_gate, // Hibernate
   input wire logic watchdog_gate, // Watchdog
   input wire logic [1:0] converter_rate_select, // Rate
   input wire logic unit_bus_fault // Fault
);
   // ****
   // Helpers
   // ****
   wire logic [4:0] g = {can_unit_zero_gate, pwm_gate, adc_gate, hibernation_gate, watchdog_gate};
   wire logic acc = psel && penable && pready;
   wire logic gate_a = paddr == 12'h100 || paddr == 12'h110 || paddr == 12'h120;
   wire logic ok_a = gate_a || paddr == 12'h060 || (paddr == 12'h1F0 && !pwrite);
   logic [31:0] last_q;
   logic rst_seen_q = 1'b0;
   // Reset already seen at the previous edge
   always @(posedge pclk) begin
      rst_seen_q <= !presetn;
   end
   // Last run register write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_q <= 32'h0;
      end else if (acc && pwrite && paddr == 12'h100) begin
         last_q <= pwdata;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_run_wr;
      acc && pwrite && paddr == 12'h100 && power_mode == 2'h0 ##1 (power_mode == 2'h0) [*2];
   endsequence
   a_setup_answer: assert property (s_setup |=> pready && penable) else $error("no ready after setup");
   a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
   a_fault_gated: assert property ((|(unit_access & ~g)) ##1 g == $past(g) |-> unit_bus_fault)
      else $error("no fault on gated access");
   a_fault_open: assert property (!(|(unit_access & ~g)) ##1 g == $past(g) |-> !unit_bus_fault)
      else $error("fault on clocked unit");
   a_rate_bound: assert property (converter_rate_select <= MAX_RATE) else $error("rate above max");
   a_reset_state: assert property (@(posedge pclk) disable iff (1'b0)
      !presetn && rst_seen_q |-> g == 5'h02 && converter_rate_select == 2'h0 && !unit_bus_fault)
      else $error("bad reset state");
   a_refuse_unmapped: assert property (acc && !ok_a |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access accepted");
   a_mapped_ok: assert property (acc && ok_a |-> !pslverr) else $error("mapped access refused");
   a_reserved_zero: assert property (acc && !pwrite && gate_a |-> (prdata & ~`PCG_GATE_MASK) == 32'h0)
      else $error("reserved bits set");
   a_run_follow: assert property (s_run_wr |-> ##[0:1]
      g == {last_q[24], last_q[20], last_q[16], last_q[6], last_q[3]}) else $error("gates not following run");
endmodule
bind pcg_top pcg_top_asserts #(.MAX_RATE(MAX_RATE)) pcg_top_asserts_inst (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .power_mode(power_mode), .unit_access(unit_access),
   .can_unit_zero_gate(can_unit_zero_gate), .pwm_gate(pwm_gate), .adc_gate(adc_gate),
   .hibernation_gate(hibernation_gate), .watchdog_gate(watchdog_gate),
   .converter_rate_select(converter_rate_select), .unit_bus_fault(unit_bus_fault));
`default_nettype wire

// file: testbench/pcg_top_tb.sv
// Purpose: self-checking bench of the gating block
// Assumes: APB master, core model for strobes
// Notes: random run register values, fixed seed
`timescale 1ns/100ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_top_tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, v, e;
   logic pready, pslverr, err, cg, pg, ag, hg, wg, unit_bus_fault;
   logic [1:0] power_mode = 2'h0, rate;
   logic [4:0] unit_access, g;
   integer mismatches = 0, check_count = 0, seed = 32'hd845, i;
   int pos [5] = '{3, 6, 16, 20, 24};
   assign g = {cg, pg, ag, hg, wg};
   always #25 pclk = ~pclk;
   pcg_top #(.MAX_RATE(2'h2)) pcg_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_mode(power_mode), .unit_access(unit_access), .can_unit_zero_gate(cg), .pwm_gate(pg),
      .adc_gate(ag), .hibernation_gate(hg), .watchdog_gate(wg), .converter_rate_select(rate),
      .unit_bus_fault(unit_bus_fault));
   pcg_core_model pcg_core_model_inst (.pclk(pclk), .unit_access(unit_access));
   // ****
   // Helpers
   // ****
   function automatic [31:0] exp_reg(input [31:0] d);
      exp_reg = d & `PCG_GATE_MASK;
      if (d[9:8] > 2'h2) exp_reg[9:8] = 2'h2;
   endfunction
   function automatic [4:0] exp_g(input [31:0] r);
      exp_g = {r[24], r[20], r[16], r[6], r[3]};
   endfunction
   task automatic chk(input [31:0] got, input [31:0] exp);
      check_count = check_count + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic settle(input [4:0] x);
      repeat (3) @(posedge pclk);
      #1 chk(g, x);
   endtask
   task automatic finish_test;
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #1000000;
      mismatches = mismatches + 1;
      finish_test;
   end
   // ****
   // Main sequence
   // ****
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
         apb(1'b0, 12'h100 + i[11:0] * 12'h010, 32'h0);
         chk(rd, `PCG_GATE_RESET);
      end
      chk(g, 5'h02);
      for (i = 0; i < 5; i = i + 1) begin
         apb(1'b1, 12'h100, 32'h1 << pos[i]);
         settle(5'h01 << i);
         pcg_core_model_inst.access(5'h1F);
         #1 chk(unit_bus_fault, 1'b1);
         pcg_core_model_inst.access(5'h01 << i);
         #1 chk(unit_bus_fault, 1'b0);
      end
      for (i = 0; i < 24; i = i + 1) begin
         v = $random(seed);
         if (i < 4) v[9:8] = i[1:0];
         if (i == 4) v = 32'hFFFFFFFF;
         e = exp_reg(v);
         apb(1'b1, 12'h100, v);
         apb(1'b0, 12'h100, 32'h0);
         chk(rd, e);
         settle(exp_g(e));
         chk(rate, e[9:8]);
         pcg_core_model_inst.access(v[29:25]);
         #1 chk(unit_bus_fault, |(v[29:25] & ~exp_g(e)));
      end
      apb(1'b1, 12'h100, 32'h00000008);
      apb(1'b1, 12'h110, 32'h01000000);
      apb(1'b1, 12'h120, 32'h00100000);
      @(posedge pclk) power_mode <= 2'h1;
      settle(5'h01);
      apb(1'b1, 12'h060, 32'h08000000);
      settle(5'h10);
      @(posedge pclk) power_mode <= 2'h2;
      settle(5'h08);
      @(posedge pclk) power_mode <= 2'h0;
      settle(5'h01);
      @(posedge pclk) power_mode <= 2'h3;
      settle(5'h01);
      apb(1'b0, 12'h1F0, 32'h0);
      chk(rd, 32'h00000001);
      chk(err, 1'b0);
      apb(1'b0, 12'h200, 32'h0);
      chk(rd, 32'h00000000);
      chk(err, 1'b1);
      apb(1'b1, 12'h1F0, 32'hFFFFFFFF);
      chk(err, 1'b1);
      presetn <= 1'b0;
      #1 chk(g, 5'h02);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 12'h110, 32'h0);
      chk(rd, `PCG_GATE_RESET);
      finish_test;
   end
endmodule
`default_nettype wire

// file: verilog/pcg_consts.vh
// Purpose: constants for the peripheral clock gating block
// Assumes: APB byte addressing, 32-bit data
// Notes: definitions only
`ifndef PCG_CONSTS_VH
`define PCG_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define PCG_SYSCTL_BASE 32'h400FE000
`define PCG_OFF_RUN_GATE 12'h100
`define PCG_OFF_SLEEP_GATE 12'h110
`define PCG_OFF_DSLEEP_GATE 12'h120
`define PCG_OFF_RUN_CFG 12'h060
`define PCG_OFF_MODE 12'h1F0

// ****************************************
// Field positions
// ****************************************
`define PCG_BIT_CAN_ZERO 24
`define PCG_BIT_PWM 20
`define PCG_BIT_ADC 16
`define PCG_BIT_HIBERNATE 6
`define PCG_BIT_WATCHDOG 3
`define PCG_RATE_HI 9
`define PCG_RATE_LO 8
`define PCG_BIT_AUTO 27
`define PCG_GATE_MASK 32'h01110348
`define PCG_CFG_MASK 32'h08000000

// ****************************************
// Reset values and codes
// ****************************************
`define PCG_GATE_RESET 32'h00000040
`define PCG_CFG_RESET 32'h00000000
`define PCG_RATE_125K 2'h0
`define PCG_RATE_250K 2'h1
`define PCG_RATE_500K 2'h2
`define PCG_MODE_RUN 2'h0
`define PCG_MODE_SLEEP 2'h1
`define PCG_MODE_DSLEEP 2'h2
`define PCG_UNITS 5

`endif

// file: verilog/pcg_gate_reg.v
// Purpose: one clock gating register with masked writable bits
// Assumes: write strobe is one cycle
// Notes: reserved bits read as zero
`timescale 1ns/100ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_gate_reg #(
   parameter [31:0] RESET_VAL = `PCG_GATE_RESET,
   parameter [31:0] WR_MASK = `PCG_GATE_MASK,
   parameter [1:0] MAX_RATE = `PCG_RATE_500K
) (
   input wire pclk, // Clock
   input wire presetn, // Async reset, low
   input wire wr_en, // Write strobe
   input wire [31:0] wdata, // Write data
   output wire [31:0] value // Stored value
);
   reg [31:0] value_q;
   reg [31:0] value_d;
   reg [1:0] rate;

   // ****************************************
   // Next value
   // ****************************************
   // Masked write with rate clamp
   always @* begin
      value_d = wdata & WR_MASK;
      rate = wdata[`PCG_RATE_HI:`PCG_RATE_LO];
      // RULE10 clamp to maximum
      if (rate > MAX_RATE) begin
         rate = MAX_RATE;
      end
      value_d[`PCG_RATE_HI:`PCG_RATE_LO] = rate & WR_MASK[`PCG_RATE_HI:`PCG_RATE_LO];
   end

   // Storage
   always @(posedge pclk or negedge presetn) begin
      // RULE7 gates reset to RESET_VAL, 0x40 leaves hibernation on
      if (!presetn) begin
         value_q <= RESET_VAL;
      end else if (wr_en) begin
         value_q <= value_d;
      end
   end

   // RULE13 reserved read zero
   assign value = value_q & WR_MASK;
endmodule
`default_nettype wire

// file: verilog/pcg_top.v
// Purpose: peripheral clock gating registers and unit enables
// Assumes: APB slave, pclk 20 MHz, unit accesses flagged by system bus
// Notes: effective gates follow run/sleep/deep-sleep state
//    one access cycle per transfer, no wait states
//    gate, rate and fault outputs lag their inputs by one cycle
//    status word at 0x1F0 is read-only, writes get an error
//
// Operation
// RULE1 - bit 24 clocks CAN unit zero
// RULE2 - bit 20 clocks PWM module
// RULE3 - bit 16 clocks converter zero
// RULE4 - bit 6 clocks hibernation module
// RULE5 - bit 3 clocks watchdog
// RULE6 - access to gated unit gives fault
// RULE7 - gate bits reset to zero unless stated
// RULE8 - sleep register resets to 0x40
// RULE9 - bits 9:8 select converter rate
// RULE10 - rate never exceeds part maximum
// RULE11 - run, sleep, deep-sleep registers same layout
// RULE12 - sleep registers need automatic gating bit
// RULE13 - reserved bits read zero
// RULE14 - sleep register at offset 0x110
// RULE15 - run register at 0x100, reset 0x40
// RULE16 - without automatic gating, run settings apply
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "pcg_consts.vh"
module pcg_top #(
   parameter [1:0] MAX_RATE = `PCG_RATE_500K
) (
   input wire pclk, // Clock
   input wire presetn, // Async reset, low
   input wire psel, // APB select
   input wire penable, // APB enable
   input wire pwrite, // APB direction
   input wire [11:0] paddr, // APB byte address
   input wire [31:0] pwdata, // APB write data
   output reg [31:0] prdata, // APB read data
   output reg pready, // APB ready
   output reg pslverr, // APB error
   input wire [1:0] power_mode, // 0 run, 1 sleep, 2 deep sleep
   input wire [4:0] unit_access, // Access strobes: can,pwm,adc,hibernate,watchdog
   output reg can_unit_zero_gate, // CAN clock enable
   output reg pwm_gate, // PWM clock enable
   output reg adc_gate, // Converter clock enable
   output reg hibernation_gate, // Hibernation clock enable
   output reg watchdog_gate, // Watchdog clock enable
   output reg [1:0] converter_rate_select, // Effective rate code
   output reg unit_bus_fault // Fault on gated access
);
   wire [31:0] run_val;
   wire [31:0] sleep_val;
   wire [31:0] dsleep_val;
   wire [31:0] cfg_val;
   wire [4:0] fault_vec;
   reg [31:0] eff_gate;
   reg [4:0] eff_vec;
   reg [31:0] rdata_d;
   reg rd_err;
   wire access;
   wire wr_run;
   wire wr_sleep;
   wire wr_dsleep;
   wire wr_cfg;
   wire auto_gating_select;
   wire setup;
   wire hit_run;
   wire hit_sleep;
   wire hit_dsleep;
   wire hit_cfg;
   wire hit_mode;

   // ****************************************
   // APB decode
   // ****************************************
   // Setup phase of a transfer
   assign setup = psel & ~penable;
   // Access phase qualifies writes
   assign access = psel & penable & pready;
   // Register hits on the address
   // RULE15 run offset hit
   assign hit_run = (paddr == `PCG_OFF_RUN_GATE);
   // RULE14 sleep offset hit
   assign hit_sleep = (paddr == `PCG_OFF_SLEEP_GATE);
   assign hit_dsleep = (paddr == `PCG_OFF_DSLEEP_GATE);
   assign hit_cfg = (paddr == `PCG_OFF_RUN_CFG);
   assign hit_mode = (paddr == `PCG_OFF_MODE);

   // Write strobes, one per register
   // RULE15 run register write
   assign wr_run = access & pwrite & hit_run;
   // RULE14 sleep register write
   assign wr_sleep = access & pwrite & hit_sleep;
   assign wr_dsleep = access & pwrite & hit_dsleep;
   assign wr_cfg = access & pwrite & hit_cfg;

   // ****************************************
   // Registers
   // ****************************************
   // RULE11 three same-layout registers
   // RULE15 run reset value
   pcg_gate_reg #(
      .RESET_VAL(`PCG_GATE_RESET),
      .WR_MASK(`PCG_GATE_MASK),
      .MAX_RATE(MAX_RATE)
   ) u_run (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_run),
      .wdata(pwdata),
      .value(run_val)
   );

   // RULE8 sleep reset value
   pcg_gate_reg #(
      .RESET_VAL(`PCG_GATE_RESET),
      .WR_MASK(`PCG_GATE_MASK),
      .MAX_RATE(MAX_RATE)
   ) u_sleep (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_sleep),
      .wdata(pwdata),
      .value(sleep_val)
   );

   pcg_gate_reg #(
      .RESET_VAL(`PCG_GATE_RESET),
      .WR_MASK(`PCG_GATE_MASK),
      .MAX_RATE(MAX_RATE)
   ) u_dsleep (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_dsleep),
      .wdata(pwdata),
      .value(dsleep_val)
   );

   // Configuration register with automatic gating bit
   pcg_gate_reg #(
      .RESET_VAL(`PCG_CFG_RESET),
      .WR_MASK(`PCG_CFG_MASK),
      .MAX_RATE(2'h3)
   ) u_cfg (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_cfg),
      .wdata(pwdata),
      .value(cfg_val)
   );

   assign auto_gating_select = cfg_val[`PCG_BIT_AUTO];

   // ****************************************
   // Effective gate selection
   // ****************************************
   // Pick register for current power mode
   always @* begin
      eff_gate = run_val;
      // RULE12 sleep sets need auto bit
      if (auto_gating_select) begin
         case (power_mode)
            `PCG_MODE_SLEEP: begin
               eff_gate = sleep_val;
            end
            `PCG_MODE_DSLEEP: begin
               eff_gate = dsleep_val;
            end
            default: begin
               eff_gate = run_val;
            end
         endcase
      end
      // RULE16 run settings otherwise
      eff_vec = {eff_gate[`PCG_BIT_CAN_ZERO], eff_gate[`PCG_BIT_PWM], eff_gate[`PCG_BIT_ADC],
                 eff_gate[`PCG_BIT_HIBERNATE], eff_gate[`PCG_BIT_WATCHDOG]};
   end

   // ****************************************
   // Fault checks
   // ****************************************
   // RULE6 CAN access check
   pcg_unit_guard u_guard_can (
      .enable(eff_vec[4]),
      .unit_sel(unit_access[4]),
      .fault(fault_vec[4])
   );

   // RULE6 PWM access check
   pcg_unit_guard u_guard_pwm (
      .enable(eff_vec[3]),
      .unit_sel(unit_access[3]),
      .fault(fault_vec[3])
   );

   // RULE6 converter access check
   pcg_unit_guard u_guard_adc (
      .enable(eff_vec[2]),
      .unit_sel(unit_access[2]),
      .fault(fault_vec[2])
   );

   // RULE6 hibernation access check
   pcg_unit_guard u_guard_hibernate (
      .enable(eff_vec[1]),
      .unit_sel(unit_access[1]),
      .fault(fault_vec[1])
   );

   // RULE6 watchdog access check
   pcg_unit_guard u_guard_watchdog (
      .enable(eff_vec[0]),
      .unit_sel(unit_access[0]),
      .fault(fault_vec[0])
   );

   // ****************************************
   // Read mux
   // ****************************************
   // Read data and unmapped address error
   always @* begin
      rd_err = 1'b0;
      case (paddr)
         `PCG_OFF_RUN_GATE: begin
            rdata_d = run_val;
         end
         `PCG_OFF_SLEEP_GATE: begin
            rdata_d = sleep_val;
         end
         `PCG_OFF_DSLEEP_GATE: begin
            rdata_d = dsleep_val;
         end
         `PCG_OFF_RUN_CFG: begin
            rdata_d = cfg_val;
         end
         // Status word carries the effective gates
         `PCG_OFF_MODE: begin
            rdata_d = {27'h0, eff_vec};
         end
         default: begin
            rdata_d = 32'h00000000;
            rd_err = 1'b1;
         end
      endcase
   end

   // ****************************************
   // APB response
   // ****************************************
   // Ready one cycle after setup, registered data
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata <= pwrite ? 32'h00000000 : rdata_d;
            pslverr <= rd_err | (pwrite & hit_mode);
         end else begin
            pslverr <= 1'b0;
         end
      end
   end

   // ****************************************
   // Unit outputs
   // ****************************************
   // Registered clock enables
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         can_unit_zero_gate <= 1'b0;
         pwm_gate <= 1'b0;
         adc_gate <= 1'b0;
         // Hibernation on, as in the 0x40 reset value
         hibernation_gate <= 1'b1;
         watchdog_gate <= 1'b0;
      end else begin
         // RULE1 CAN gate
         can_unit_zero_gate <= eff_vec[4];
         // RULE2 PWM gate
         pwm_gate <= eff_vec[3];
         // RULE3 converter gate
         adc_gate <= eff_vec[2];
         // RULE4 hibernation gate
         hibernation_gate <= eff_vec[1];
         // RULE5 watchdog gate
         watchdog_gate <= eff_vec[0];
      end
   end

   // Registered rate code and fault pulse
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         converter_rate_select <= `PCG_RATE_125K;
         unit_bus_fault <= 1'b0;
      end else begin
         // RULE9 rate field
         converter_rate_select <= eff_gate[`PCG_RATE_HI:`PCG_RATE_LO];
         // RULE6 fault pulse
         unit_bus_fault <= |fault_vec;
      end
   end
endmodule
`default_nettype wire

// file: verilog/pcg_unit_guard.v
// Purpose: gate enable and access fault check for one unit
// Assumes: select is one cycle wide per access attempt
// Notes: output is registered in the top
`timescale 1ns/100ps
`default_nettype none
module pcg_unit_guard (
   input wire enable, // Effective gate bit
   input wire unit_sel, // Access aimed at unit
   output wire fault // Access to gated unit
);
   // RULE6 gated unit faults
   assign fault = unit_sel & ~enable;
endmodule
`default_nettype wire
